/* common/pcs_consts.vh */
// Constants for the 16-bit card control strobe block
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// Cycle kinds requested by the host side
`define PCS_CYC_IO_RD 3'h0
`define PCS_CYC_IO_WR 3'h1
`define PCS_CYC_MEM_RD 3'h2
`define PCS_CYC_MEM_WR 3'h3
`define PCS_CYC_DMA_RD 3'h4
`define PCS_CYC_DMA_WR 3'h5

// Setup 100 ns, strobe 300 ns, hold 50 ns, counted in 50 ns clock cycles
`define PCS_SETUP_CYC 4'h2
`define PCS_STROBE_CYC 4'h6
`define PCS_HOLD_CYC 4'h1

// Width of the phase counter
`define PCS_CNT_W 4

// Idle level of every active-low strobe
`define PCS_STROBE_IDLE 1'h1

`endif

/* hw/pcs_status_sync.v */
// Two-stage capture of the card-driven status inputs
`timescale 1ns/1ps
`default_nettype none
module pcs_status_sync (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Raw inputs, active low
	input wire [2:0] raw_n_in,
	// Synchronised levels, active low
	output wire [2:0] sync_n_out
);
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_bit
			reg stage1;
			reg stage2;
			// Idle high so that no acknowledge or interrupt looks asserted out of reset
			always @(posedge clk_in) begin
				if (rst_in) begin
					stage1 <= 1'h1;
					stage2 <= 1'h1;
				end else begin
					stage1 <= raw_n_in[i];
					stage2 <= stage1;
				end
			end
			assign sync_n_out[i] = stage2;
		end
	endgenerate
endmodule // pcs_status_sync
`default_nettype wire

/* hw/pcs_strobes.v */
// Control strobe sequencer for a 16-bit card socket
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.vh"

// Overview of operation
// - The controller asserts the I/O read strobe in host I/O read cycles so the card drives data.
// - The I/O read strobe serves as DMA write strobe for transfers from card to host memory.
// - The controller drives the I/O write strobe low in host I/O write cycles to latch data.
// - The I/O write strobe is asserted for DMA transfers from host memory to the card.
// - The controller drives output enable low in host memory reads so the memory card drives data.
// - Output enable is asserted as terminal count in DMA write operations from the card to host memory.
// - The shared ready/interrupt input is ready only when card and socket are in memory-only mode.
// - The first card enable selects even bytes and the second selects odd bytes.
// - Attribute select is asserted as DMA acknowledge together with the data strobe in DMA.
module pcs_strobes (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Host cycle request
	input wire req_valid_in,
	input wire [2:0] req_kind_in,
	input wire req_addr0_in,
	input wire req_wide_in,
	input wire req_last_in,
	output wire req_ready_out,
	output reg done_out,
	// Socket mode
	input wire memory_only_in,
	// Card status pins: input acknowledge active low; shared pin high for ready, low for interrupt
	input wire input_ack_n_in,
	input wire ready_irq_in,
	// Card strobe pins, active low
	output reg io_read_strobe_n_out,
	output reg io_write_strobe_n_out,
	output reg output_enable_n_out,
	output reg write_enable_n_out,
	output reg even_byte_select_n_out,
	output reg odd_byte_select_n_out,
	output reg attr_select_n_out,
	// Status to host
	output reg card_ready_out,
	output reg card_irq_out,
	output reg input_ack_out,
	output reg dma_request_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_SETUP = 2'h1;
	localparam ST_STROBE = 2'h2;
	localparam ST_HOLD = 2'h3;
	localparam [3:0] SETUP_CYC = `PCS_SETUP_CYC;
	localparam [3:0] STROBE_CYC = `PCS_STROBE_CYC;
	localparam [3:0] HOLD_CYC = `PCS_HOLD_CYC;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [3:0] count;
	reg [3:0] next_count;
	reg [2:0] kind;
	reg addr0;
	reg wide;
	reg last;
	wire [2:0] synced_n;
	wire strobe_on;
	wire [2:0] sel_kind;
	wire sel_addr0;
	wire sel_wide;
	wire sel_dma;

	pcs_status_sync u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.raw_n_in({ready_irq_in, input_ack_n_in, 1'h1}),
		.sync_n_out(synced_n)
	);

	assign req_ready_out = (state == ST_IDLE);
	assign strobe_on = (state == ST_STROBE);
	// Selects leave idle on the take edge, the same edge that latches the request, so use the live request
	assign sel_kind = req_ready_out ? req_kind_in : kind;
	assign sel_addr0 = req_ready_out ? req_addr0_in : addr0;
	assign sel_wide = req_ready_out ? req_wide_in : wide;
	assign sel_dma = (sel_kind == `PCS_CYC_DMA_RD) || (sel_kind == `PCS_CYC_DMA_WR);

	always @* begin
		next_state = state;
		next_count = count;
		case (state)
			ST_IDLE: begin
				if (req_valid_in) begin
					next_state = ST_SETUP;
					next_count = SETUP_CYC - 4'h1;
				end
			end
			ST_SETUP: begin
				if (count == 4'h0) begin
					next_state = ST_STROBE;
					next_count = STROBE_CYC - 4'h1;
				end else begin
					next_count = count - 4'h1;
				end
			end
			ST_STROBE: begin
				if (count == 4'h0) begin
					next_state = ST_HOLD;
					next_count = HOLD_CYC - 4'h1;
				end else begin
					next_count = count - 4'h1;
				end
			end
			ST_HOLD: begin
				if (count == 4'h0) begin
					next_state = ST_IDLE;
				end else begin
					next_count = count - 4'h1;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_count = 4'h0;
			end
		endcase
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			count <= 4'h0;
			kind <= 3'h0;
			addr0 <= 1'h0;
			wide <= 1'h0;
			last <= 1'h0;
			done_out <= 1'h0;
		end else begin
			state <= next_state;
			count <= next_count;
			done_out <= (state == ST_HOLD) && (count == 4'h0);
			if (req_ready_out && req_valid_in) begin
				kind <= req_kind_in;
				addr0 <= req_addr0_in;
				wide <= req_wide_in;
				last <= req_last_in;
			end
		end
	end

	// Address and byte selects span setup through hold; data strobes only the middle phase
	always @(posedge clk_in) begin
		if (rst_in) begin
			io_read_strobe_n_out <= `PCS_STROBE_IDLE;
			io_write_strobe_n_out <= `PCS_STROBE_IDLE;
			output_enable_n_out <= `PCS_STROBE_IDLE;
			write_enable_n_out <= `PCS_STROBE_IDLE;
			even_byte_select_n_out <= `PCS_STROBE_IDLE;
			odd_byte_select_n_out <= `PCS_STROBE_IDLE;
			attr_select_n_out <= `PCS_STROBE_IDLE;
		end else if (next_state == ST_IDLE) begin
			io_read_strobe_n_out <= `PCS_STROBE_IDLE;
			io_write_strobe_n_out <= `PCS_STROBE_IDLE;
			output_enable_n_out <= `PCS_STROBE_IDLE;
			write_enable_n_out <= `PCS_STROBE_IDLE;
			even_byte_select_n_out <= `PCS_STROBE_IDLE;
			odd_byte_select_n_out <= `PCS_STROBE_IDLE;
			attr_select_n_out <= `PCS_STROBE_IDLE;
		end else begin
			// Even select for even address or wide, odd select for odd or wide
			even_byte_select_n_out <= ~(~sel_addr0 | sel_wide);
			odd_byte_select_n_out <= ~(sel_addr0 | sel_wide);
			attr_select_n_out <= ~sel_dma;
			io_read_strobe_n_out <= ~((next_state == ST_STROBE) &&
				((kind == `PCS_CYC_IO_RD) || (kind == `PCS_CYC_DMA_RD)));
			io_write_strobe_n_out <= ~((next_state == ST_STROBE) &&
				((kind == `PCS_CYC_IO_WR) || (kind == `PCS_CYC_DMA_WR)));
			// Terminal count rides on output enable while the card writes into host memory
			output_enable_n_out <= ~((next_state == ST_STROBE) &&
				((kind == `PCS_CYC_MEM_RD) ||
				((kind == `PCS_CYC_DMA_RD) && last)));
			write_enable_n_out <= ~((next_state == ST_STROBE) &&
				((kind == `PCS_CYC_MEM_WR) ||
				((kind == `PCS_CYC_DMA_WR) && last)));
		end
	end

	// The shared pin means ready only in memory-only mode, interrupt otherwise
	always @(posedge clk_in) begin
		if (rst_in) begin
			card_ready_out <= 1'h0;
			card_irq_out <= 1'h0;
			input_ack_out <= 1'h0;
			dma_request_out <= 1'h0;
		end else begin
			card_ready_out <= memory_only_in & synced_n[2];
			card_irq_out <= ~memory_only_in & ~synced_n[2];
			// Acknowledge matters only while an I/O read strobe is out
			input_ack_out <= ~synced_n[1] & strobe_on & (kind == `PCS_CYC_IO_RD);
			dma_request_out <= ~synced_n[1] & ~memory_only_in & ~strobe_on;
		end
	end
endmodule // pcs_strobes
`default_nettype wire

/* bench/pcs_card_model.sv */
// Behavioural 16-bit card seen from the socket
`timescale 1ns/1ps
`default_nettype none
module pcs_card_model (
	// Clock and socket strobes
	input wire logic clk_in,
	input wire logic rd_n_in,
	input wire logic we_n_in,
	// Bench controls
	input wire logic mem_mode_in,
	input wire logic flag_in,
	// Card status pins
	output logic ack_n_out,
	output logic rdy_irq_out
);
	logic [2:0] busy = 3'h0;
	always @(posedge clk_in) begin
		if (!we_n_in) begin
			busy <= 3'h7;
		end else if (busy != 3'h0) begin
			busy <= busy - 3'h1;
		end
	end
	// Flag doubles as DMA request and interrupt so one bench control covers both
	assign ack_n_out = rd_n_in & ~flag_in;
	assign rdy_irq_out = mem_mode_in ? (busy == 3'h0) : ~flag_in;
endmodule // pcs_card_model
`default_nettype wire

/* bench/pcs_strobes_assertions.sv */
// Strobe timing checker for the card socket sequencer
`timescale 1ns/1ps
`default_nettype none
module pcs_strobes_assertions (
	// Observed ports
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_valid_in,
	input wire logic [2:0] req_kind_in,
	input wire logic req_addr0_in,
	input wire logic req_wide_in,
	input wire logic req_last_in,
	input wire logic req_ready_out,
	input wire logic io_read_strobe_n_out,
	input wire logic io_write_strobe_n_out,
	input wire logic output_enable_n_out,
	input wire logic even_byte_select_n_out,
	input wire logic odd_byte_select_n_out,
	input wire logic attr_select_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Windows of two edges tolerate where the registered strobe is first sampled
	wire logic take = req_valid_in && req_ready_out;
	wire logic [2:0] k = req_kind_in;
	a_io_rd_low: assert property (take && k == 3'h0 |-> ##[3:4] !io_read_strobe_n_out)
		else $error("io read strobe late");
	a_io_wr_low: assert property (take && k == 3'h1 |-> ##[3:4] !io_write_strobe_n_out)
		else $error("io write strobe late");
	a_mem_rd_oe: assert property (take && k == 3'h2 |-> ##[3:4] !output_enable_n_out)
		else $error("output enable late");
	a_dma_in_ack: assert property (take && k == 3'h4 |->
		##[3:4] (!io_read_strobe_n_out && !attr_select_n_out)) else $error("dma in strobes");
	a_dma_out_ack: assert property (take && k == 3'h5 |->
		##[3:4] (!io_write_strobe_n_out && !attr_select_n_out)) else $error("dma out strobes");
	a_rd_width: assert property ($fell(io_read_strobe_n_out) |->
		!io_read_strobe_n_out [*6] ##1 io_read_strobe_n_out) else $error("read strobe width");
	a_even_sel: assert property (take && !req_wide_in && !req_addr0_in |->
		##1 (!even_byte_select_n_out && odd_byte_select_n_out)) else $error("even select");
	a_odd_sel: assert property (take && !req_wide_in && req_addr0_in |->
		##1 (even_byte_select_n_out && !odd_byte_select_n_out)) else $error("odd select");
	a_dma_tc: assert property (take && k == 3'h4 && req_last_in |->
		##[3:4] !output_enable_n_out) else $error("terminal count missing");
	a_idle_high: assert property (req_ready_out |->
		(io_read_strobe_n_out && io_write_strobe_n_out && output_enable_n_out))
		else $error("strobe low while idle");
endmodule // pcs_strobes_assertions
bind pcs_strobes pcs_strobes_assertions chk (.*);
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the card strobe sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module tb_top;
	logic clk_in = 1'h0, rst_in = 1'h1, req_valid_in = 1'h0, req_addr0_in = 1'h0;
	logic req_wide_in = 1'h0, req_last_in = 1'h0, memory_only_in = 1'h0, flag = 1'h0;
	logic [2:0] req_kind_in = 3'h0;
	wire logic req_ready_out, done_out, io_read_strobe_n_out, io_write_strobe_n_out;
	wire logic output_enable_n_out, write_enable_n_out, even_byte_select_n_out;
	wire logic odd_byte_select_n_out, attr_select_n_out, card_ready_out, card_irq_out;
	wire logic input_ack_out, dma_request_out, input_ack_n_in, ready_irq_in;
	wire logic [6:0] strobes_n = {io_read_strobe_n_out, io_write_strobe_n_out,
		output_enable_n_out, write_enable_n_out, even_byte_select_n_out,
		odd_byte_select_n_out, attr_select_n_out};
	int n_fail = 0, checks_done = 0, ticks = 0;
	initial forever #25 clk_in = ~clk_in;
	pcs_strobes dut (.*);
	pcs_card_model card (.clk_in(clk_in), .rd_n_in(io_read_strobe_n_out),
		.we_n_in(write_enable_n_out), .mem_mode_in(memory_only_in), .flag_in(flag),
		.ack_n_out(input_ack_n_in), .rdy_irq_out(ready_irq_in));
	task automatic test_done;
		$display("Compares %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_in) begin
		ticks++;
		if (ticks == 2000) begin
			n_fail++;
			test_done();
		end
	end
	// One socket cycle from idle; records every strobe that went low
	task automatic cyc(input logic [2:0] kd, input logic a0, wd, lst, input logic [6:0] ex);
		logic [6:0] seen;
		logic ack;
		seen = 7'h00;
		ack = 1'h0;
		@(posedge clk_in);
		req_kind_in <= kd;
		req_addr0_in <= a0;
		req_wide_in <= wd;
		req_last_in <= lst;
		req_valid_in <= 1'h1;
		@(posedge clk_in);
		req_valid_in <= 1'h0;
		for (int i = 0; i < 20 && done_out !== 1'h1; i++) begin
			@(posedge clk_in);
			#1;
			seen = seen | ~strobes_n;
			ack = ack | input_ack_out;
		end
		`CHK("strobes low", ex, seen)
		`CHK("idle strobes", 7'h7F, strobes_n)
		`CHK("input ack", kd == 3'h0, ack)
		`CHK("ready idle", 1'h1, req_ready_out)
	endtask
	task automatic t_host;
		cyc(3'h0, 1'h0, 1'h0, 1'h0, 7'h44);
		cyc(3'h1, 1'h1, 1'h0, 1'h0, 7'h22);
		cyc(3'h2, 1'h0, 1'h1, 1'h0, 7'h16);
		cyc(3'h3, 1'h0, 1'h1, 1'h0, 7'h0E);
	endtask
	task automatic t_dma;
		cyc(3'h4, 1'h0, 1'h1, 1'h0, 7'h47);
		cyc(3'h4, 1'h0, 1'h1, 1'h1, 7'h57);
		cyc(3'h5, 1'h1, 1'h0, 1'h0, 7'h23);
		cyc(3'h5, 1'h0, 1'h1, 1'h1, 7'h2F);
	endtask
	// Ready only counts in memory mode; the same pin means interrupt otherwise
	task automatic t_status;
		@(posedge clk_in);
		memory_only_in <= 1'h1;
		cyc(3'h3, 1'h0, 1'h1, 1'h0, 7'h0E);
		`CHK("busy card", 1'h0, card_ready_out)
		repeat (12) @(posedge clk_in);
		#1;
		`CHK("ready card", 1'h1, card_ready_out)
		@(posedge clk_in);
		memory_only_in <= 1'h0;
		flag <= 1'h1;
		repeat (6) @(posedge clk_in);
		#1;
		`CHK("irq out", 1'h1, card_irq_out)
		`CHK("ready masked", 1'h0, card_ready_out)
		`CHK("dma request", 1'h1, dma_request_out)
	endtask
	initial begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'h0;
		t_host();
		t_dma();
		t_status();
		test_done();
	end
endmodule // tb_top
`default_nettype wire
